// >>> dv/rpgfs_host_model.sv
// Purpose: host side of the register port
// Assumes: one request per taking edge
// Notes: released address and data show inverted values
`timescale 1ns/100ps
module rpgfs_host_model (
  input wire logic clock, // system clock
  input wire rpgfs_pkg::rpgfs_rsp_s regRsp, // answer
  output rpgfs_pkg::rpgfs_req_s regReq // request
);
  import rpgfs_pkg::*;
  initial regReq = '0;
  // one byte; answer taken once the taking edge has landed
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
    output logic [7:0] q);
    @(posedge clock);
    #1 regReq = '{addr: a, wdata: d, write: w, read: r};
    @(posedge clock);
    #1 regReq = '{addr: ~a, wdata: ~d, write: 1'b0, read: 1'b0};
    q = (regRsp.valid === 1'b1) ? regRsp.rdata : 8'hxx;
  endtask : xfer
  // write held over n taking edges back to back
  task automatic hold_write(input logic [7:0] a, input logic [7:0] d, input int n);
    @(posedge clock);
    #1 regReq = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    repeat (n) @(posedge clock);
    #1 regReq = '{addr: ~a, wdata: ~d, write: 1'b0, read: 1'b0};
  endtask : hold_write
endmodule : rpgfs_host_model

// >>> dv/rpgfs_status_bank_properties.sv
// Purpose: port checks of the rail status bank
// Assumes: reset held at least two edges
// Notes: a fault may latch on the edge of the fall or the one after
`timescale 1ns/100ps
module rpgfs_status_bank_properties (
  input wire logic clock, // system clock
  input wire logic sys_rst, // sync reset
  input wire rpgfs_pkg::rpgfs_rails_s railGood, // raw levels
  input wire rpgfs_pkg::rpgfs_req_s regReq, // request
  input wire rpgfs_pkg::rpgfs_rsp_s regRsp, // answer
  input wire rpgfs_pkg::rpgfs_grp1_s faultFlags, // faults
  input wire rpgfs_pkg::rpgfs_rails_s goodFlags // good levels
);
  import rpgfs_pkg::*;
  logic [7:0] prevGood;
  logic [7:0] fellReg;
  logic [7:0] fellVec;
  // falls kept one more edge so either latch timing passes
  assign fellVec = prevGood & ~goodFlags.grp1;
  always_ff @(posedge clock) begin
    prevGood <= sys_rst ? 8'h00 : goodFlags.grp1;
    fellReg <= sys_rst ? 8'h00 : fellVec;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence readAt(logic [7:0] a);
    regReq.read && regReq.addr == a;
  endsequence
  sequence clearTaken;
    regReq.write && regReq.addr == RPGFS_OFF_FAULT1 &&
      ((fellVec | fellReg) & regReq.wdata) == 0;
  endsequence
  valid_after_read_a: assert property (regReq.read |=> regRsp.valid)
    else $error("read not answered");
  valid_only_read_a: assert property (regRsp.valid |-> $past(regReq.read))
    else $error("answer without read");
  fault_read_a: assert property (
    readAt(RPGFS_OFF_FAULT1) |=> regRsp.rdata == $past(faultFlags))
    else $error("fault read wrong");
  good_one_read_a: assert property (
    readAt(RPGFS_OFF_GOOD1) |=> regRsp.rdata == $past(goodFlags.grp1))
    else $error("good1 read wrong");
  good_two_read_a: assert property (
    readAt(RPGFS_OFF_GOOD2) |=> regRsp.rdata == {2'h0, $past(goodFlags.grp2)})
    else $error("good2 read wrong");
  fault_sticky_a: assert property (
    !(regReq.write && regReq.addr == RPGFS_OFF_FAULT1)
    |=> (faultFlags & $past(faultFlags)) == $past(faultFlags))
    else $error("fault dropped");
  fault_set_a: assert property (
    fellReg != 0 |-> (faultFlags & fellReg) == fellReg)
    else $error("fault not set");
  fault_clear_a: assert property (
    clearTaken |=> (faultFlags & $past(regReq.wdata)) == 0)
    else $error("fault not cleared");
endmodule : rpgfs_status_bank_properties
bind rpgfs_status_bank rpgfs_status_bank_properties i_props (.clock(clock), .sys_rst(sys_rst),
  .railGood(railGood), .regReq(regReq), .regRsp(regRsp), .faultFlags(faultFlags),
  .goodFlags(goodFlags));

// >>> dv/test_rail_power_good_fault_status.sv
// Purpose: register level test of the rail status bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: six idle cycles let the filter settle
`timescale 1ns/100ps
module test_rail_power_good_fault_status;
  import rpgfs_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  rpgfs_rails_s railGood = '0;
  rpgfs_req_s regReq;
  rpgfs_rsp_s regRsp;
  rpgfs_grp1_s faultFlags;
  rpgfs_rails_s goodFlags;
  int nMismatch = 0;
  int cmpCount = 0;
  logic [7:0] q;
  logic [13:0] one;
  logic [7:0] exp1;
  logic [7:0] exp2;
  always #20 clock = ~clock;
  rpgfs_status_bank i_dut (.clock(clock), .sys_rst(sys_rst), .railGood(railGood),
    .regReq(regReq), .regRsp(regRsp), .faultFlags(faultFlags), .goodFlags(goodFlags));
  rpgfs_host_model i_host (.clock(clock), .regRsp(regRsp), .regReq(regReq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    i_host.xfer(a, 8'h00, 1'b0, 1'b1, v);
    chk(v, exp, what);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    i_host.xfer(a, d, 1'b1, 1'b0, v);
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // watchdog, far beyond the roughly 255 cycles the tests need
  initial begin
    #400000;
    nMismatch++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    report_and_stop();
  end
  initial begin
    idle(2);
    sys_rst = 1'b0;
    rd(RPGFS_OFF_GOOD1, RPGFS_RST_GOOD1, "good1 reset");
    rd(RPGFS_OFF_GOOD2, RPGFS_RST_GOOD2, "good2 reset");
    rd(RPGFS_OFF_FAULT1, RPGFS_RST_FAULT1, "fault reset");
    rd(8'hb3, RPGFS_UNMAPPED, "unmapped");
    $display("test reset done");
    // one good rail at a time; writes to good registers must not stick
    for (int i = 0; i < RPGFS_RAILS; i++) begin
      one = 14'h0001 << i;
      exp1 = one[13:6];
      exp2 = {2'h0, one[5:0]};
      railGood = one;
      idle(6);
      chk(goodFlags.grp1, exp1, "good1 port");
      chk({2'h0, goodFlags.grp2}, exp2, "good2 port");
      wr(RPGFS_OFF_GOOD1, 8'hff);
      wr(RPGFS_OFF_GOOD2, 8'hff);
      rd(RPGFS_OFF_GOOD1, exp1, "good1");
      rd(RPGFS_OFF_GOOD2, exp2, "good2");
    end
    railGood = '0;
    idle(6);
    rd(RPGFS_OFF_FAULT1, 8'hff, "faults latched");
    chk(faultFlags, 8'hff, "fault port");
    $display("test rail map done");
    wr(RPGFS_OFF_FAULT1, 8'h0f);
    rd(RPGFS_OFF_FAULT1, 8'hf0, "part clear");
    wr(RPGFS_OFF_FAULT1, 8'h00);
    rd(RPGFS_OFF_FAULT1, 8'hf0, "zero write");
    i_host.xfer(RPGFS_OFF_FAULT1, 8'hf0, 1'b1, 1'b1, q);
    chk(q, 8'hf0, "read with clear");
    rd(RPGFS_OFF_FAULT1, 8'h00, "all clear");
    $display("test clear done");
    // clears end on the very edge the new fault latches
    railGood.grp1.auxTwo = 1'b1;
    idle(6);
    railGood.grp1.auxTwo = 1'b0;
    i_host.hold_write(RPGFS_OFF_FAULT1, 8'h80, 4);
    idle(3);
    rd(RPGFS_OFF_FAULT1, 8'h80, "set wins");
    // a rail that comes back leaves its fault flag set
    railGood.grp1.auxTwo = 1'b1;
    idle(6);
    rd(RPGFS_OFF_FAULT1, 8'h80, "sticky after recovery");
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    rd(RPGFS_OFF_FAULT1, RPGFS_RST_FAULT1, "fault rereset");
    $display("test set priority done");
    report_and_stop();
  end
endmodule : test_rail_power_good_fault_status

// >>> hw/rpgfs_pkg.sv
// Purpose: shared constants and carrier types for the rail status bank
// Assumes: 8-bit register port of the device's serial interface engine
// Notes: offsets are the device's byte addresses on that port
package rpgfs_pkg;

  // register offsets
  localparam logic [7:0] RPGFS_OFF_GOOD1 = 8'hb0;
  localparam logic [7:0] RPGFS_OFF_GOOD2 = 8'hb1;
  localparam logic [7:0] RPGFS_OFF_FAULT1 = 8'hb2;

  // values after reset
  localparam logic [7:0] RPGFS_RST_GOOD1 = 8'h00;
  localparam logic [7:0] RPGFS_RST_GOOD2 = 8'h00;
  localparam logic [7:0] RPGFS_RST_FAULT1 = 8'h00;
  localparam logic [7:0] RPGFS_RST_RDATA = 8'h00;

  // answer to an unmapped read and to reserved bits
  localparam logic [7:0] RPGFS_UNMAPPED = 8'h00;
  localparam logic [1:0] RPGFS_RSVD2 = 2'h0;

  // field positions in the first group (good and fault share them)
  localparam int RPGFS_BIT_AUX_TWO = 7;
  localparam int RPGFS_BIT_A_SWITCH = 6;
  localparam int RPGFS_BIT_STEPDOWN_HI = 5;
  localparam int RPGFS_BIT_STEPDOWN_LO = 0;

  // field positions in the second good register
  localparam int RPGFS_BIT_FIVE_VOLT = 5;
  localparam int RPGFS_BIT_AUX_ONE = 4;
  localparam int RPGFS_BIT_TERMINATION = 3;
  localparam int RPGFS_BIT_B_SWITCH_TWO = 2;
  localparam int RPGFS_BIT_B_SWITCH_ONE = 1;
  localparam int RPGFS_BIT_AUX_THREE = 0;

  // number of monitored rails, first group plus second group
  localparam int RPGFS_RAILS1 = 8;
  localparam int RPGFS_RAILS2 = 6;
  localparam int RPGFS_RAILS = 14;

  // first group of rails, packed in register bit order
  typedef struct packed {
    logic auxTwo;         // bit 7
    logic aSwitch;        // bit 6
    logic [5:0] stepdown; // bits 5..0 = rails six..one
  } rpgfs_grp1_s;

  // second group of rails, packed in register bit order (bits 5..0)
  typedef struct packed {
    logic fiveVolt;
    logic auxOne;
    logic termination;
    logic bSwitchTwo;
    logic bSwitchOne;
    logic auxThree;
  } rpgfs_grp2_s;

  // all comparator results of the device
  typedef struct packed {
    rpgfs_grp1_s grp1;
    rpgfs_grp2_s grp2;
  } rpgfs_rails_s;

  // register access request from the serial interface engine
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } rpgfs_req_s;

  // register read answer
  typedef struct packed {
    logic [7:0] rdata;
    logic valid;
  } rpgfs_rsp_s;

endpackage : rpgfs_pkg

// >>> hw/rpgfs_status_bank.sv
// Purpose: power-good and power-fault status registers of the rail monitor
// Assumes: register port driven by the serial interface engine on this clock
// Notes: good flags are live, fault flags are sticky and cleared by writing one
//
// Overview of operation
// - each good bit reads 1 while its rail is in regulation, else 0
// - first good register bit 7 shows auxiliary regulator two
// - first good register bit 6 shows the A-side load switch
// - first good register bits 5..0 show step-down rails six..one
// - second good register at B1h: bit 5 five-volt rail, bits 7:6 read zero
// - second good register bit 4 shows auxiliary regulator one
// - second good register bit 3 shows the memory termination regulator
// - second good register bits 2 and 1 show B-side switches two and one
// - second good register bit 0 shows auxiliary regulator three
// - both good registers are read-only and zero after reset
// - fault register at B2h resets to zero, bit order as first good register
// - fault bit sets on loss of regulation and stays set after recovery
// - host writes one to a fault bit and the device clears it
// - first good register sits at B0h and resets to zero
`timescale 1ns/100ps
module rpgfs_status_bank (
  input wire logic clock,                        // 25 MHz system clock
  input wire logic sys_rst,                      // synchronous reset, active high
  input wire rpgfs_pkg::rpgfs_rails_s railGood,  // raw comparator levels, 1 = in window
  input wire rpgfs_pkg::rpgfs_req_s regReq,      // register access request
  output rpgfs_pkg::rpgfs_rsp_s regRsp,          // registered read answer
  output rpgfs_pkg::rpgfs_grp1_s faultFlags,     // sticky fault flags, from a flop
  output rpgfs_pkg::rpgfs_rails_s goodFlags      // filtered good levels, from a flop
);
  import rpgfs_pkg::*;

  // address match, used for reads and for the clear path
  function automatic logic hitsOffset(input logic [7:0] addr, input logic [7:0] off);
    hitsOffset = (addr == off);
  endfunction : hitsOffset

  // read multiplexer over the three mapped registers
  function automatic logic [7:0] readMux(
    input logic [7:0] addr,
    input logic [7:0] good1,
    input logic [7:0] good2,
    input logic [7:0] fault1
  );
    if (hitsOffset(addr, RPGFS_OFF_GOOD1)) begin
      readMux = good1;
    end else if (hitsOffset(addr, RPGFS_OFF_GOOD2)) begin
      readMux = good2;
    end else if (hitsOffset(addr, RPGFS_OFF_FAULT1)) begin
      readMux = fault1;
    end else begin
      readMux = RPGFS_UNMAPPED;
    end
  endfunction : readMux

  // all state of this block
  typedef struct packed {
    logic [RPGFS_RAILS1-1:0] goodPrev1; // last filtered good of the first group
    logic [RPGFS_RAILS1-1:0] fault1;    // sticky fault flags
    logic [7:0] rdata;                  // read answer data
    logic rvalid;                       // read answer strobe
  } rpgfs_bank_state_s;

  rpgfs_bank_state_s state_reg;
  rpgfs_bank_state_s state_next;

  logic [RPGFS_RAILS-1:0] cleanLevel;
  rpgfs_rails_s goodNow;
  logic [7:0] good1Word;
  logic [7:0] good2Word;
  logic [RPGFS_RAILS1-1:0] lossEvent;
  logic [RPGFS_RAILS1-1:0] clearMask;

  // comparator levels are asynchronous; filter them before any use
  rpgfs_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .rawLevel(railGood),
    .cleanLevel(cleanLevel)
  );

  // the filtered vector keeps the packed order of the rails struct
  assign goodNow = cleanLevel;

  // first good register: live levels, no storage of its own
  always_comb begin
    good1Word = RPGFS_RST_GOOD1;
    good1Word[RPGFS_BIT_AUX_TWO] = goodNow.grp1.auxTwo;
    good1Word[RPGFS_BIT_A_SWITCH] = goodNow.grp1.aSwitch;
    good1Word[RPGFS_BIT_STEPDOWN_HI:RPGFS_BIT_STEPDOWN_LO] =
      goodNow.grp1.stepdown;
  end

  // second good register: reserved bits 7:6 always read zero
  always_comb begin
    good2Word = RPGFS_RST_GOOD2;
    good2Word[7:6] = RPGFS_RSVD2;
    good2Word[RPGFS_BIT_FIVE_VOLT] = goodNow.grp2.fiveVolt;
    good2Word[RPGFS_BIT_AUX_ONE] = goodNow.grp2.auxOne;
    good2Word[RPGFS_BIT_TERMINATION] = goodNow.grp2.termination;
    good2Word[RPGFS_BIT_B_SWITCH_TWO] = goodNow.grp2.bSwitchTwo;
    good2Word[RPGFS_BIT_B_SWITCH_ONE] = goodNow.grp2.bSwitchOne;
    good2Word[RPGFS_BIT_AUX_THREE] = goodNow.grp2.auxThree;
  end

  // loss of regulation is the filtered good level falling from 1 to 0;
  // a rail that has never come up does not raise a fault, which keeps the
  // flags quiet during power-up sequencing
  always_comb begin
    lossEvent = state_reg.goodPrev1 & ~good1Word;
  end

  // write-one-to-clear mask; zeros in the data and writes to any other
  // offset, including the read-only good registers, clear nothing
  always_comb begin
    clearMask = '0;
    if (regReq.write && hitsOffset(regReq.addr, RPGFS_OFF_FAULT1)) begin
      clearMask = regReq.wdata;
    end
  end

  // next state
  always_comb begin
    state_next = state_reg;
    state_next.goodPrev1 = good1Word;
    // set wins over clear so a loss in the clearing cycle is kept
    state_next.fault1 = (state_reg.fault1 & ~clearMask) | lossEvent;
    state_next.rvalid = regReq.read;
    if (regReq.read) begin
      // reads only sample; nothing is cleared by reading
      state_next.rdata = readMux(regReq.addr, good1Word, good2Word,
        state_reg.fault1);
    end
  end

  // state register; fault flags and read data start at zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg.goodPrev1 <= RPGFS_RST_GOOD1;
      state_reg.fault1 <= RPGFS_RST_FAULT1;
      state_reg.rdata <= RPGFS_RST_RDATA;
      state_reg.rvalid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs, all straight from flops
  assign regRsp.rdata = state_reg.rdata;
  assign regRsp.valid = state_reg.rvalid;
  assign faultFlags = state_reg.fault1;
  assign goodFlags = goodNow;

endmodule : rpgfs_status_bank

// >>> hw/rpgfs_sync.sv
// Purpose: three-stage synchroniser with agreement filter for comparator levels
// Assumes: inputs come from analog comparators outside the clock domain
// Notes: stage one is read only by stage two
`timescale 1ns/100ps
module rpgfs_sync (
  input wire logic clock,                                  // 25 MHz system clock
  input wire logic sys_rst,                                // synchronous reset, active high
  input wire logic [rpgfs_pkg::RPGFS_RAILS-1:0] rawLevel,  // asynchronous comparator levels
  output logic [rpgfs_pkg::RPGFS_RAILS-1:0] cleanLevel     // filtered level, from a flop
);
  import rpgfs_pkg::*;

  typedef struct packed {
    logic [RPGFS_RAILS-1:0] stage1;
    logic [RPGFS_RAILS-1:0] stage2;
    logic [RPGFS_RAILS-1:0] stage3;
    logic [RPGFS_RAILS-1:0] clean;
  } rpgfs_sync_state_s;

  rpgfs_sync_state_s state_reg;
  rpgfs_sync_state_s state_next;

  // a level only counts once stages two and three agree, so a metastable
  // settle in stage two cannot produce a one-cycle glitch downstream
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = rawLevel;
    state_next.stage2 = state_reg.stage1;
    state_next.stage3 = state_reg.stage2;
    for (int i = 0; i < RPGFS_RAILS; i++) begin
      if (state_reg.stage2[i] == state_reg.stage3[i]) begin
        state_next.clean[i] = state_reg.stage3[i];
      end
    end
  end

  // state register; all zero after reset so every rail reads not good
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cleanLevel = state_reg.clean;

endmodule : rpgfs_sync
